// File: hw/ocf_fault_response.sv
// Overcurrent fault response sequencer with its configuration registers
`timescale 1ns/1ps

// Summary of operation
// - Code 00: limit current forever, ignore output voltage.
// - Code 01: limit while voltage above low limit, else shut down and retry.
// - Code 10: limit for delay time; still limiting at expiry, shut down and retry.
// - Code 11: output off while overcurrent persists, back on when gone.
// - Bits 5:3 give restart attempts; 000 none, 111 endless.
// - Zero retries: stay off until the fault is cleared.
// - Bits 2:0 give time of two to the field value units.
// - Any response sets the overcurrent fault flag and alerts the host if enabled.
// - Time unit comes from the register at command 0xD2.
module ocf_fault_response #(
  parameter bit NOTIFY_SUPPORTED = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_cmd,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  input wire logic i_oc_detect,
  input wire logic i_lv_detect,
  input wire logic i_fault_clear,
  output logic o_output_en,
  output logic o_current_limit,
  output logic o_oc_fault,
  output logic o_host_alert,
  output logic [2:0] o_retries_left,
  output ocf_pkg::ocf_state_e o_state
);
  import ocf_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] fault_action_reg;
  logic [7:0] time_unit_reg;
  logic [7:0] rdata_reg;
  logic [1:0] oc_sync_reg;
  logic [1:0] lv_sync_reg;
  logic oc_now;
  logic lv_now;
  logic [1:0] mode;
  logic [2:0] retry_cfg;
  ocf_state_e state_reg;
  ocf_state_e state_next;
  logic [2:0] retry_cnt_reg;
  logic fault_reg;
  logic shut_down;
  logic restart;
  logic timer_start;
  logic fault_event;

  ocf_timer_if tif ();

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      oc_sync_reg <= '0;
      lv_sync_reg <= '0;
    end else begin
      oc_sync_reg <= {oc_sync_reg[0], i_oc_detect};
      lv_sync_reg <= {lv_sync_reg[0], i_lv_detect};
    end
  end

  assign oc_now = oc_sync_reg[1];
  assign lv_now = lv_sync_reg[1];

  ////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fault_action_reg <= OCF_FAULT_ACTION_RST;
      time_unit_reg <= OCF_TIME_UNIT_RST;
    end else if (i_cfg_wr) begin
      if (i_cfg_cmd == OCF_CMD_FAULT_ACTION) begin
        fault_action_reg <= i_cfg_wdata;
      end
      if (i_cfg_cmd == OCF_CMD_TIME_UNIT) begin
        time_unit_reg <= i_cfg_wdata;
      end
    end
  end

  // Registered readback, unknown commands read zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= '0;
    end else begin
      case (i_cfg_cmd)
        OCF_CMD_FAULT_ACTION: begin
          rdata_reg <= fault_action_reg;
        end
        OCF_CMD_TIME_UNIT: begin
          rdata_reg <= time_unit_reg;
        end
        default: begin
          rdata_reg <= '0;
        end
      endcase
    end
  end

  assign mode = fault_action_reg[OCF_MODE_HI:OCF_MODE_LO];
  assign retry_cfg = fault_action_reg[OCF_RETRY_HI:OCF_RETRY_LO];

  ////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    shut_down = 1'b0;
    restart = 1'b0;
    timer_start = 1'b0;
    case (state_reg)
      OCF_RUN: begin
        if (oc_now) begin
          if (mode == OCF_MODE_DISABLE) begin
            state_next = OCF_HOLD_OFF;
          end else begin
            state_next = OCF_LIMIT;
            timer_start = (mode == OCF_MODE_DELAY);
          end
        end
      end
      OCF_LIMIT: begin
        if (!oc_now) begin
          state_next = OCF_RUN;
        end else if (mode == OCF_MODE_DISABLE) begin
          state_next = OCF_HOLD_OFF;
        end else if (mode == OCF_MODE_LV_SHUT && lv_now) begin
          shut_down = 1'b1;
        end else if (mode == OCF_MODE_DELAY && (tif.done || !tif.busy)) begin
          shut_down = 1'b1;
        end
      end
      OCF_RETRY_WAIT: begin
        if (tif.done) begin
          restart = 1'b1;
          state_next = OCF_RUN;
        end
      end
      OCF_LATCHED: begin
        if (i_fault_clear) begin
          state_next = OCF_RUN;
        end
      end
      OCF_HOLD_OFF: begin
        if (!oc_now) begin
          state_next = OCF_RUN;
        end
      end
      default: begin
        state_next = OCF_RUN;
      end
    endcase
    if (shut_down) begin
      if (retry_cnt_reg == OCF_RETRY_NONE) begin
        state_next = OCF_LATCHED;
      end else begin
        state_next = OCF_RETRY_WAIT;
        timer_start = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= OCF_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Retry counter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      retry_cnt_reg <= OCF_RETRY_NONE;
    end else if (i_fault_clear || (i_cfg_wr && i_cfg_cmd == OCF_CMD_FAULT_ACTION)) begin
      retry_cnt_reg <= (i_cfg_wr && i_cfg_cmd == OCF_CMD_FAULT_ACTION)
        ? i_cfg_wdata[OCF_RETRY_HI:OCF_RETRY_LO] : retry_cfg;
    end else if (restart && retry_cnt_reg != OCF_RETRY_FOREVER) begin
      retry_cnt_reg <= retry_cnt_reg - OCF_RETRY_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Fault flag, set wins over clear
  assign fault_event = (state_reg == OCF_RUN) && oc_now;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fault_reg <= 1'b0;
    end else if (fault_event) begin
      fault_reg <= 1'b1;
    end else if (i_fault_clear) begin
      fault_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Timer hookup
  assign tif.start = timer_start;
  assign tif.exponent = fault_action_reg[OCF_TIME_HI:OCF_TIME_LO];
  assign tif.unit_sel = time_unit_reg;

  ocf_delay_timer u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .tif(tif)
  );

  ////////////////////////////////////////////////////////////////
  // Outputs
  assign o_cfg_rdata = rdata_reg;
  assign o_state = state_reg;
  assign o_retries_left = retry_cnt_reg;
  assign o_output_en = (state_reg == OCF_RUN) || (state_reg == OCF_LIMIT);
  assign o_current_limit = (state_reg == OCF_LIMIT);
  assign o_oc_fault = fault_reg;
  assign o_host_alert = fault_reg && NOTIFY_SUPPORTED;

endmodule

// File: hw/ocf_pkg.sv
// Constants and types for the overcurrent fault response block
package ocf_pkg;

  // Command codes of the two configuration registers
  localparam logic [7:0] OCF_CMD_FAULT_ACTION = 8'h47;
  localparam logic [7:0] OCF_CMD_TIME_UNIT = 8'hD2;

  // Reset values
  localparam logic [7:0] OCF_FAULT_ACTION_RST = 8'h00;
  localparam logic [7:0] OCF_TIME_UNIT_RST = 8'h00;

  // Field positions of the fault action register
  localparam int OCF_MODE_HI = 7;
  localparam int OCF_MODE_LO = 6;
  localparam int OCF_RETRY_HI = 5;
  localparam int OCF_RETRY_LO = 3;
  localparam int OCF_TIME_HI = 2;
  localparam int OCF_TIME_LO = 0;

  // Response codes
  localparam logic [1:0] OCF_MODE_IGNORE = 2'h0;
  localparam logic [1:0] OCF_MODE_LV_SHUT = 2'h1;
  localparam logic [1:0] OCF_MODE_DELAY = 2'h2;
  localparam logic [1:0] OCF_MODE_DISABLE = 2'h3;

  // Retry counts
  localparam logic [2:0] OCF_RETRY_NONE = 3'h0;
  localparam logic [2:0] OCF_RETRY_FOREVER = 3'h7;
  localparam logic [2:0] OCF_RETRY_STEP = 3'h1;

  // Base time unit and clock
  localparam int OCF_CLK_PERIOD_NS = 4;
  localparam int OCF_BASE_UNIT_NS = 1000;
  localparam int OCF_BASE_UNIT_CYC = (OCF_BASE_UNIT_NS + OCF_CLK_PERIOD_NS - 1) / OCF_CLK_PERIOD_NS;
  localparam logic [8:0] OCF_BASE_LAST = 9'(OCF_BASE_UNIT_CYC - 1);
  localparam logic [7:0] OCF_ONE8 = 8'h01;

  // Fault sequencing states, Gray coded along the usual path
  typedef enum logic [2:0] {
    OCF_RUN = 3'b000,
    OCF_LIMIT = 3'b001,
    OCF_RETRY_WAIT = 3'b011,
    OCF_LATCHED = 3'b010,
    OCF_HOLD_OFF = 3'b110
  } ocf_state_e;

endpackage

// File: hw/ocf_timer_if.sv
// Carrier between the fault sequencer and its delay timer
`timescale 1ns/1ps
interface ocf_timer_if;
  logic start;
  logic [2:0] exponent;
  logic [7:0] unit_sel;
  logic done;
  logic busy;

  modport ctrl (output start, output exponent, output unit_sel, input done, input busy);
  modport tmr (input start, input exponent, input unit_sel, output done, output busy);
endinterface

// File: hw/ocf_delay_timer.sv
// Retry and delay timer: 2^exponent time units
`timescale 1ns/1ps
module ocf_delay_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  ocf_timer_if.tmr tif
);
  import ocf_pkg::*;

  logic [8:0] base_cnt_reg;
  logic [7:0] unit_cnt_reg;
  logic [7:0] span_cnt_reg;
  logic busy_reg;
  logic done_reg;
  logic [7:0] span_last;
  logic base_tick;
  logic unit_tick;

  ////////////////////////////////////////////////////////////////
  // Span of two to the exponent
  assign span_last = (OCF_ONE8 << tif.exponent) - OCF_ONE8;
  assign base_tick = busy_reg && (base_cnt_reg == OCF_BASE_LAST);
  // Unit length from time unit register
  assign unit_tick = base_tick && (unit_cnt_reg == tif.unit_sel);

  ////////////////////////////////////////////////////////////////
  // Base prescaler, one microsecond
  always_ff @(posedge i_clk) begin
    if (i_rst || tif.start || base_tick) begin
      base_cnt_reg <= '0;
    end else if (busy_reg) begin
      base_cnt_reg <= base_cnt_reg + 9'h001;
    end
  end

  // Time units of (unit_sel + 1) microseconds
  always_ff @(posedge i_clk) begin
    if (i_rst || tif.start || unit_tick) begin
      unit_cnt_reg <= '0;
    end else if (base_tick) begin
      unit_cnt_reg <= unit_cnt_reg + 8'h01;
    end
  end

  // Units elapsed and completion
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      span_cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (tif.start) begin
        span_cnt_reg <= '0;
        busy_reg <= 1'b1;
      end else if (unit_tick) begin
        if (span_cnt_reg == span_last) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          span_cnt_reg <= span_cnt_reg + 8'h01;
        end
      end
    end
  end

  assign tif.done = done_reg;
  assign tif.busy = busy_reg;
endmodule

// File: verif/ocf_fault_response_chk.sv
// Assertion checker for the overcurrent fault response block
`timescale 1ns/1ps
module ocf_fault_response_chk
  import ocf_pkg::*;
#(
  parameter bit NOTIFY_SUPPORTED = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_cmd,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic i_fault_clear,
  input wire logic o_output_en,
  input wire logic o_current_limit,
  input wire logic o_oc_fault,
  input wire logic o_host_alert,
  input wire logic [2:0] o_retries_left,
  input wire ocf_pkg::ocf_state_e o_state
);
  logic [1:0] mode_reg;
  ////////////////////////////////////////////////////////////
  // Shadow of the response field
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_reg <= 2'h0;
    end else if (i_cfg_wr && i_cfg_cmd == OCF_CMD_FAULT_ACTION) begin
      mode_reg <= i_cfg_wdata[7:6];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  limit_flag_a: assert property (o_current_limit == (o_state == OCF_LIMIT))
    else $error("limit flag disagrees with state");
  ignore_hold_a: assert property (o_state == OCF_LIMIT && mode_reg == OCF_MODE_IGNORE && !i_cfg_wr
    |=> o_state inside {OCF_LIMIT, OCF_RUN}) else $error("ignore mode left limiting");
  output_en_a: assert property (o_output_en == (o_state inside {OCF_RUN, OCF_LIMIT}))
    else $error("output enable disagrees with state");
  fault_set_a: assert property (o_state == OCF_RUN ##1 o_state != OCF_RUN |-> o_oc_fault)
    else $error("fault flag not set on fault");
  fault_sticky_a: assert property (o_oc_fault && !i_fault_clear |=> o_oc_fault)
    else $error("fault flag dropped without clear");
  host_alert_a: assert property (o_host_alert == (NOTIFY_SUPPORTED && o_oc_fault))
    else $error("alert does not follow fault flag");
  wait_count_a: assert property (o_state == OCF_RETRY_WAIT |-> o_retries_left != OCF_RETRY_NONE)
    else $error("retry wait with no retries left");
  latch_hold_a: assert property (o_state == OCF_LATCHED && !i_fault_clear && !i_cfg_wr
    |=> o_state == OCF_LATCHED) else $error("latched off left without clear");
  retry_step_a: assert property (o_state == OCF_RETRY_WAIT && !i_fault_clear && !i_cfg_wr ##1 o_state == OCF_RUN
    |-> o_retries_left == ($past(o_retries_left) == OCF_RETRY_FOREVER ? OCF_RETRY_FOREVER
    : $past(o_retries_left) - OCF_RETRY_STEP)) else $error("retry count step wrong");
endmodule

bind ocf_fault_response ocf_fault_response_chk #(.NOTIFY_SUPPORTED(NOTIFY_SUPPORTED)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_cfg_wr(i_cfg_wr), .i_cfg_cmd(i_cfg_cmd), .i_cfg_wdata(i_cfg_wdata),
  .i_fault_clear(i_fault_clear), .o_output_en(o_output_en), .o_current_limit(o_current_limit),
  .o_oc_fault(o_oc_fault), .o_host_alert(o_host_alert), .o_retries_left(o_retries_left), .o_state(o_state)
);

// File: verif/ocf_load_model.sv
// Load model that drives overcurrent and undervoltage after a set lag
`timescale 1ns/1ps
module ocf_load_model (
  input wire logic i_clk,
  input wire logic i_want_oc,
  input wire logic i_want_lv,
  input wire logic [3:0] i_lag,
  output logic o_oc_detect,
  output logic o_lv_detect
);
  logic [3:0] cnt_reg = 4'h0;
  initial begin
    o_oc_detect = 1'b0;
    o_lv_detect = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_want_oc == o_oc_detect && i_want_lv == o_lv_detect) begin
      cnt_reg <= i_lag;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else begin
      o_oc_detect <= i_want_oc;
      o_lv_detect <= i_want_lv;
    end
  end
endmodule

// File: verif/test_ocf_fault_response.sv
// Self-checking testbench for the overcurrent fault response block
`timescale 1ns/1ps
module test_ocf_fault_response;
  import ocf_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_cfg_wr = 1'b0;
  logic [7:0] i_cfg_cmd = 8'h00;
  logic [7:0] i_cfg_wdata = 8'h00;
  logic i_fault_clear = 1'b0;
  logic want_oc = 1'b0;
  logic want_lv = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [7:0] o_cfg_rdata;
  logic oc_det, lv_det, o_output_en, o_current_limit, o_oc_fault, o_host_alert;
  logic [2:0] o_retries_left;
  ocf_state_e o_state;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  always #2 i_clk = ~i_clk;
  ocf_load_model load (.i_clk(i_clk), .i_want_oc(want_oc), .i_want_lv(want_lv), .i_lag(lag),
    .o_oc_detect(oc_det), .o_lv_detect(lv_det));
  ocf_fault_response dut (.i_clk(i_clk), .i_rst(i_rst), .i_cfg_wr(i_cfg_wr), .i_cfg_cmd(i_cfg_cmd),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_oc_detect(oc_det), .i_lv_detect(lv_det),
    .i_fault_clear(i_fault_clear), .o_output_en(o_output_en), .o_current_limit(o_current_limit),
    .o_oc_fault(o_oc_fault), .o_host_alert(o_host_alert), .o_retries_left(o_retries_left), .o_state(o_state));
  ////////////////////////////////////////////////////////////
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    i_cfg_wr = 1'b1;
    i_cfg_cmd = cmd;
    i_cfg_wdata = data;
    step(1);
    i_cfg_wr = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    i_cfg_cmd = cmd;
    step(1);
    chk(o_cfg_rdata, exp);
  endtask
  task automatic clear;
    i_fault_clear = 1'b1;
    step(1);
    i_fault_clear = 1'b0;
  endtask
  task automatic wait_for(input ocf_state_e s, input int lim);
    n = 0;
    while (o_state !== s && n < lim) begin
      step(1);
      n++;
    end
    chk(8'(o_state), 8'(s));
  endtask
  task automatic end_sim;
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    fail_count++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    step(12);
    i_rst = 1'b0;
    rd(OCF_CMD_FAULT_ACTION, OCF_FAULT_ACTION_RST);
    rd(OCF_CMD_TIME_UNIT, OCF_TIME_UNIT_RST);
    chk(8'(o_output_en), 8'h01);
    wr(OCF_CMD_TIME_UNIT, 8'h5A);
    wr(OCF_CMD_FAULT_ACTION, 8'hA5);
    wr(8'h46, 8'hFF);
    rd(OCF_CMD_TIME_UNIT, 8'h5A);
    rd(OCF_CMD_FAULT_ACTION, 8'hA5);
    rd(8'h46, 8'h00);
    chk(8'(o_retries_left), 8'h04);
    wr(OCF_CMD_TIME_UNIT, 8'h00);
    wr(OCF_CMD_FAULT_ACTION, 8'h00);
    want_oc = 1'b1;
    wait_for(OCF_LIMIT, 20);
    chk(8'({o_oc_fault, o_host_alert}), 8'h03);
    want_lv = 1'b1;
    step(600);
    chk(8'({o_state, o_output_en}), 8'({OCF_LIMIT, 1'b1}));
    chk(8'(o_current_limit), 8'h01);
    want_oc = 1'b0;
    want_lv = 1'b0;
    wait_for(OCF_RUN, 20);
    clear();
    lag = 4'h5;
    wr(OCF_CMD_FAULT_ACTION, 8'hC0);
    want_oc = 1'b1;
    wait_for(OCF_HOLD_OFF, 30);
    step(100);
    chk(8'({o_state, o_output_en}), 8'({OCF_HOLD_OFF, 1'b0}));
    want_oc = 1'b0;
    wait_for(OCF_RUN, 30);
    chk(8'({o_output_en, o_oc_fault}), 8'h03);
    clear();
    chk(8'(o_oc_fault), 8'h00);
    lag = 4'h0;
    wr(OCF_CMD_FAULT_ACTION, 8'h40);
    want_oc = 1'b1;
    wait_for(OCF_LIMIT, 20);
    step(50);
    chk(8'(o_state), 8'(OCF_LIMIT));
    want_lv = 1'b1;
    wait_for(OCF_LATCHED, 20);
    want_oc = 1'b0;
    want_lv = 1'b0;
    step(300);
    chk(8'({o_state, o_output_en}), 8'({OCF_LATCHED, 1'b0}));
    clear();
    wait_for(OCF_RUN, 10);
    wr(OCF_CMD_TIME_UNIT, 8'h01);
    wr(OCF_CMD_FAULT_ACTION, 8'h8A);
    want_oc = 1'b1;
    wait_for(OCF_LIMIT, 20);
    wait_for(OCF_RETRY_WAIT, 3000);
    chk(8'(n inside {[2000:2001]}), 8'h01);
    chk(8'({o_retries_left, o_output_en}), 8'h02);
    wait_for(OCF_RUN, 3000);
    chk(8'(n inside {[2000:2001]}), 8'h01);
    chk(8'(o_retries_left), 8'h00);
    wait_for(OCF_LATCHED, 5000);
    want_oc = 1'b0;
    step(5);
    clear();
    wr(OCF_CMD_TIME_UNIT, 8'h00);
    wr(OCF_CMD_FAULT_ACTION, 8'hB8);
    want_oc = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wait_for(OCF_RETRY_WAIT, 400);
      wait_for(OCF_RUN, 400);
      chk(8'(n inside {[250:251]}), 8'h01);
      chk(8'(o_retries_left), 8'(OCF_RETRY_FOREVER));
    end
    want_oc = 1'b0;
    step(20);
    end_sim();
  end
endmodule
